// ### core/eamr_regs.sv
// Purpose: EEE and auto-negotiation MMD register bank behind an Avalon-MM slave
// Assumes: Energy-efficient enable and partner advertisement arrive from other domains
// Notes:   Bus held in wait until the advertisement default has been captured

`timescale 1ns/1ps

// Operation
// R1: AN devices-present low word reads fixed: AN bit 7, PCS bit 3, rest zero.
// R2: AN devices-present high word reads fixed: bit 14 one, bits 15 and 13 zero.
// R3: Local 100BASE-TX EEE advertise bit is read/write, reset copies the enable bit.
// R4: Software must not set the advertise bit while energy-efficient mode is off. The bank does not block such a write; it is taken whatever the enable level.
// R5: Partner 100BASE-TX EEE bit mirrors remote advertisement, zero after reset.
// R6: Partner bits 6 to 2 report unsupported modes, read-only, zero by default.
// R7: Vendor MMD identifier words are read-only fixed identifier values.
// R8: Vendor MMD devices-present low word reads AN and PCS present, writes ignored.
// R9: Writes to reserved and read-only positions are ignored; fixed values persist.
module eamr_regs
  import eamr_pkg::*;
#(
  parameter logic [REG_W-1:0] VENDOR_ID_HIGH = 16'h5a3c, // Arbitrary identifier value
  parameter logic [REG_W-1:0] VENDOR_ID_LOW  = 16'h1e2d  // Arbitrary identifier value
)
(
  input  wire logic                clk_sys,                      // System clock
  input  wire logic                rst_n,                        // Async reset, active low
  input  wire logic [ADDR_W-1:0]   avs_address,                  // Word address
  input  wire logic                avs_read,                     // Read request
  input  wire logic                avs_write,                    // Write request
  input  wire logic [DATA_W-1:0]   avs_writedata,                // Write data
  input  wire logic [BE_W-1:0]     avs_byteenable,               // Byte lanes
  output logic      [DATA_W-1:0]   avs_readdata,                 // Read data
  output logic                     avs_waitrequest,              // Stall
  output logic      [1:0]          avs_response,                 // 0 okay, 3 decode error
  input  wire logic                energy_efficient_mode_enable, // EEE config level
  input  wire logic [LP_ADV_W-1:0] partner_eee_adv,              // Partner bits 6:1
  output logic                     eee_adv_100tx                 // Local advertise bit
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      A_AN_DEV_LOW,
      A_AN_DEV_HIGH,
      A_EEE_ADV,
      A_EEE_LP_ADV,
      A_VS_ID_HIGH,
      A_VS_ID_LOW,
      A_VS_DEV_LOW:
      begin
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : addr_mapped

  function automatic logic [REG_W-1:0] adv_word(input logic adv);
    logic [REG_W-1:0] w;
    w                = '0;
    w[EEE_100TX_BIT] = adv;
    return w;
  endfunction : adv_word

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic              eee_en_sync;
  logic [LP_ADV_W-1:0] lp_adv_sync;

  assign sync_in = {energy_efficient_mode_enable, partner_eee_adv};

  eamr_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_in    (sync_in),
    .q_out   (sync_out)
  );

  assign eee_en_sync = sync_out[SYNC_W-1];
  assign lp_adv_sync = sync_out[LP_ADV_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  logic [REG_W-1:0] rd_word;
  logic [REG_W-1:0] lp_word;
  eamr_regs_t       cur;
  eamr_regs_t       nxt;

  always_comb
  begin
    lp_word                                 = '0;
    lp_word[LP_ADV_LSB +: LP_ADV_W]         = lp_adv_sync; // R5 R6
  end

  always_comb
  begin
    rd_word = '0;
    case (avs_address)
      A_AN_DEV_LOW:
      begin
        rd_word = DEV_LOW_VALUE; // R1
      end
      A_AN_DEV_HIGH:
      begin
        rd_word = DEV_HIGH_VALUE; // R2
      end
      A_EEE_ADV:
      begin
        rd_word = adv_word(cur.adv_100tx); // R3
      end
      A_EEE_LP_ADV:
      begin
        rd_word = lp_word; // R5 R6
      end
      A_VS_ID_HIGH:
      begin
        rd_word = VENDOR_ID_HIGH; // R7
      end
      A_VS_ID_LOW:
      begin
        rd_word = VENDOR_ID_LOW; // R7
      end
      A_VS_DEV_LOW:
      begin
        rd_word = DEV_LOW_VALUE; // R8
      end
      default:
      begin
        rd_word = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic       req;
  logic       adv_write;

  assign req = avs_read | avs_write;

  // Only the advertise bit is writable, and only through byte lane 0
  assign adv_write = avs_write && (avs_address == A_EEE_ADV) && avs_byteenable[0]; // R9

  always_comb
  begin
    nxt = cur;
    case (cur.state)
      EAMR_ST_INIT:
      begin
        // Wait for the enable level to clear the synchroniser, then copy it
        nxt.waitreq = 1'b1;
        if (cur.init_cnt == INIT_CNT_LAST)
        begin
          nxt.adv_100tx = eee_en_sync; // R3
          nxt.state     = EAMR_ST_IDLE;
        end
        else
        begin
          nxt.init_cnt = cur.init_cnt + 2'h1;
        end
      end
      EAMR_ST_IDLE:
      begin
        nxt.waitreq = 1'b1;
        if (req)
        begin
          nxt.waitreq = 1'b0;
          nxt.state   = EAMR_ST_ACK;
          if (addr_mapped(avs_address))
          begin
            nxt.resp  = RESP_OKAY;
            nxt.rdata = avs_read ? {{(DATA_W-REG_W){1'b0}}, rd_word} : RDATA_RESET;
          end
          else
          begin
            nxt.resp  = RESP_DECERR;
            nxt.rdata = RDATA_RESET;
          end
        end
      end
      EAMR_ST_ACK:
      begin
        // Master samples waitrequest low at this edge; the write lands here
        nxt.waitreq = 1'b1;
        nxt.state   = EAMR_ST_IDLE;
        if (adv_write)
        begin
          nxt.adv_100tx = avs_writedata[EEE_100TX_BIT]; // R3 R4 R9
        end
      end
      default:
      begin
        nxt.state   = EAMR_ST_IDLE;
        nxt.waitreq = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.state     <= EAMR_ST_INIT;
      cur.init_cnt  <= 2'h0;
      cur.waitreq   <= 1'b1;
      cur.rdata     <= RDATA_RESET;
      cur.resp      <= RESP_OKAY;
      cur.adv_100tx <= 1'b0;
    end
    else
    begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata    = cur.rdata;
  assign avs_waitrequest = cur.waitreq;
  assign avs_response    = cur.resp;
  assign eee_adv_100tx   = cur.adv_100tx;

endmodule : eamr_regs

// ### core/eamr_pkg.sv
// Purpose: Shared constants and types for the EEE and auto-negotiation MMD register bank
// Assumes: Avalon-MM word addressing, 32-bit data, 16-bit registers in the low half
// Notes:   Register words sit at word addresses 0..6; upper data bits read as zero

package eamr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned BE_W   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // MMD device and register numbers of each word (management view)
  localparam int unsigned MMD_AUTONEG     = 7;
  localparam int unsigned MMD_VENDOR1     = 30;
  localparam int unsigned IDX_AN_DEV_LOW  = 5;
  localparam int unsigned IDX_AN_DEV_HIGH = 6;
  localparam int unsigned IDX_EEE_ADV     = 60;
  localparam int unsigned IDX_EEE_LP_ADV  = 61;
  localparam int unsigned IDX_VS_ID_HIGH  = 2;
  localparam int unsigned IDX_VS_ID_LOW   = 3;
  localparam int unsigned IDX_VS_DEV_LOW  = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Word addresses on the Avalon slave
  localparam logic [ADDR_W-1:0] A_AN_DEV_LOW  = 3'h0;
  localparam logic [ADDR_W-1:0] A_AN_DEV_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] A_EEE_ADV     = 3'h2;
  localparam logic [ADDR_W-1:0] A_EEE_LP_ADV  = 3'h3;
  localparam logic [ADDR_W-1:0] A_VS_ID_HIGH  = 3'h4;
  localparam logic [ADDR_W-1:0] A_VS_ID_LOW   = 3'h5;
  localparam logic [ADDR_W-1:0] A_VS_DEV_LOW  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed register contents
  localparam logic [REG_W-1:0] DEV_LOW_VALUE  = 16'h0088; // AN bit 7, PCS bit 3
  localparam logic [REG_W-1:0] DEV_HIGH_VALUE = 16'h4000; // Vendor device 1 bit 14

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned EEE_100TX_BIT = 1;
  localparam int unsigned LP_ADV_LSB    = 1;
  localparam int unsigned LP_ADV_W      = 6;  // Bits 6:1 of the partner word
  localparam int unsigned SYNC_W        = LP_ADV_W + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [1:0]        INIT_CNT_LAST = 2'h2; // Synchroniser depth
  localparam logic [DATA_W-1:0] RDATA_RESET   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    EAMR_ST_INIT,
    EAMR_ST_IDLE,
    EAMR_ST_ACK
  } eamr_state_t;

  typedef struct packed {
    eamr_state_t       state;
    logic [1:0]        init_cnt;
    logic              waitreq;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        resp;
    logic              adv_100tx;
  } eamr_regs_t;

endpackage : eamr_pkg

// ### core/eamr_sync.sv
// Purpose: Two-flop synchroniser for levels arriving from outside the register clock
// Assumes: Each bit is an independent slow level
// Notes:   Only the second stage is visible at the output

`timescale 1ns/1ps

module eamr_sync
  import eamr_pkg::*;
(
  input  wire logic              clk_sys, // System clock
  input  wire logic              rst_n,   // Async reset, active low
  input  wire logic [SYNC_W-1:0] d_in,    // Asynchronous levels
  output logic      [SYNC_W-1:0] q_out    // Synchronised levels
);

  logic [SYNC_W-1:0] stage1_ff;
  logic [SYNC_W-1:0] stage2_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= d_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign q_out = stage2_ff;

endmodule : eamr_sync

// ### test/eamr_regs_props.sv
// Purpose: Assertions on the ports of the MMD register bank
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to eamr_regs from tb_top
`timescale 1ns/1ps
module eamr_regs_props
  import eamr_pkg::*;
#(
  parameter logic [REG_W-1:0] VENDOR_ID_HIGH = 16'h3c5a, // Arbitrary value
  parameter logic [REG_W-1:0] VENDOR_ID_LOW  = 16'h2d1e  // Arbitrary value
)
(
  input wire logic [ADDR_W-1:0] avs_address,     // Address
  input wire logic              clk_sys,         // Clock
  input wire logic              rst_n,           // Reset
  input wire logic              avs_read,        // Read
  input wire logic              avs_write,       // Write
  input wire logic [DATA_W-1:0] avs_writedata,   // Write data
  input wire logic [BE_W-1:0]   avs_byteenable,  // Lanes
  input wire logic [DATA_W-1:0] avs_readdata,    // Read data
  input wire logic              avs_waitrequest, // Stall
  input wire logic [1:0]        avs_response,    // Response
  input wire logic              eee_adv_100tx    // Advertise bit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_bounded: assert property ((avs_read || avs_write) |-> ##[0:6] !avs_waitrequest)
    else $error("request not answered in time");
  a_an_low_fixed: assert property (rd_ok && avs_address == A_AN_DEV_LOW |->
    avs_readdata == {16'h0000, DEV_LOW_VALUE}) else $error("AN low word wrong");
  a_an_high_fixed: assert property (rd_ok && avs_address == A_AN_DEV_HIGH |->
    avs_readdata == {16'h0000, DEV_HIGH_VALUE}) else $error("AN high word wrong");
  a_adv_write: assert property (avs_write && !avs_waitrequest && avs_address == A_EEE_ADV
    && avs_byteenable[0] |=> eee_adv_100tx == $past(avs_writedata[1]))
    else $error("advertise bit not written");
  a_adv_read: assert property (rd_ok && avs_address == A_EEE_ADV |->
    avs_readdata == {30'h0, eee_adv_100tx, 1'b0}) else $error("advertise word wrong");
  a_vendor_id: assert property (rd_ok && avs_address == A_VS_ID_HIGH |->
    avs_readdata == {16'h0000, VENDOR_ID_HIGH}) else $error("vendor id wrong");
  a_vendor_id_low: assert property (rd_ok && avs_address == A_VS_ID_LOW |->
    avs_readdata == {16'h0000, VENDOR_ID_LOW}) else $error("vendor id low wrong");
  a_lp_reserved: assert property (rd_ok && avs_address == A_EEE_LP_ADV |->
    avs_readdata[31:7] == 25'h0 && !avs_readdata[0]) else $error("partner word reserved set");
  a_vendor_dev: assert property (rd_ok && avs_address == A_VS_DEV_LOW |->
    avs_readdata == {16'h0000, DEV_LOW_VALUE}) else $error("vendor devices word wrong");
  a_unmapped_err: assert property (!avs_waitrequest && avs_address == 3'h7 &&
    (avs_read || avs_write) |-> avs_response == RESP_DECERR && avs_readdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : eamr_regs_props

// ### test/tb_top.sv
// Purpose: Self-checking bench for the MMD register bank
// Assumes: Avalon-MM master tasks, waitrequest sampled at rising edges
// Notes:   Vendor identifier parameters are arbitrary values
`timescale 1ns/1ps
module tb_top;
  import eamr_pkg::*;
  localparam logic [15:0] VID_H = 16'h6b4e; // Arbitrary identifier value
  localparam logic [15:0] VID_L = 16'h2d71; // Arbitrary identifier value
  logic        clk_sys, rst_n, avs_read, avs_write, ee_en, avs_waitrequest, eee_adv_100tx;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rs;
  logic [5:0]  p_adv;
  int          err_count, cmp_count;
  eamr_regs #(.VENDOR_ID_HIGH(VID_H), .VENDOR_ID_LOW(VID_L)) u_eamr_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .energy_efficient_mode_enable(ee_en),
    .partner_eee_adv(p_adv), .eee_adv_100tx(eee_adv_100tx));
  always #2.5 clk_sys = ~clk_sys;
  task final_report;
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic we, input logic [2:0] a, input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      final_report();
    end
  endtask : xfer
  task rd_chk(input logic [2:0] a, input logic [31:0] exp, input logic [1:0] r);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
    chk({30'h0, rs}, {30'h0, r});
  endtask : rd_chk
  task do_reset(input logic en);
    rst_n <= 1'b0;
    ee_en <= en;
    p_adv <= 6'h00;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(A_EEE_ADV, {30'h0, en, 1'b0}, RESP_OKAY);
    chk({31'h0, eee_adv_100tx}, {31'h0, en});
    rd_chk(A_EEE_LP_ADV, 32'h0, RESP_OKAY);
  endtask : do_reset
  task sc_fixed;
    logic [2:0]  ad [5];
    logic [15:0] ex [5];
    ad = '{A_AN_DEV_LOW, A_AN_DEV_HIGH, A_VS_ID_HIGH, A_VS_ID_LOW, A_VS_DEV_LOW};
    ex = '{DEV_LOW_VALUE, DEV_HIGH_VALUE, VID_H, VID_L, DEV_LOW_VALUE};
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(ad[i], {16'h0, ex[i]}, RESP_OKAY);
      xfer(1'b1, ad[i], 32'hffff_ffff, 4'hf);
      rd_chk(ad[i], {16'h0, ex[i]}, RESP_OKAY);
    end
  endtask : sc_fixed
  task sc_adv;
    xfer(1'b1, A_EEE_ADV, 32'h0, 4'hf);
    rd_chk(A_EEE_ADV, 32'h0, RESP_OKAY);
    chk({31'h0, eee_adv_100tx}, 32'h0);
    xfer(1'b1, A_EEE_ADV, 32'hffff_ffff, 4'he);
    rd_chk(A_EEE_ADV, 32'h0, RESP_OKAY);
    xfer(1'b1, A_EEE_ADV, 32'hffff_ffff, 4'hf);
    rd_chk(A_EEE_ADV, 32'h2, RESP_OKAY);
    chk({31'h0, eee_adv_100tx}, 32'h1);
  endtask : sc_adv
  task sc_partner;
    p_adv <= 6'h01;
    repeat (4) @(posedge clk_sys);
    rd_chk(A_EEE_LP_ADV, 32'h2, RESP_OKAY);
    p_adv <= 6'h3e;
    repeat (4) @(posedge clk_sys);
    rd_chk(A_EEE_LP_ADV, 32'h7c, RESP_OKAY);
    xfer(1'b1, A_EEE_LP_ADV, 32'h0, 4'hf);
    rd_chk(A_EEE_LP_ADV, 32'h7c, RESP_OKAY);
    xfer(1'b1, 3'h7, 32'hffff_ffff, 4'hf);
    chk({30'h0, rs}, {30'h0, RESP_DECERR});
    rd_chk(3'h7, 32'h0, RESP_DECERR);
    rd_chk(A_EEE_ADV, 32'h2, RESP_OKAY);
  endtask : sc_partner
  initial
  begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    err_count = 0;
    cmp_count = 0;
    do_reset(1'b1);
    sc_fixed();
    sc_adv();
    sc_partner();
    do_reset(1'b0);
    final_report();
  end
endmodule : tb_top
bind eamr_regs eamr_regs_props #(.VENDOR_ID_HIGH(VENDOR_ID_HIGH), .VENDOR_ID_LOW(VENDOR_ID_LOW))
  u_props (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .eee_adv_100tx(eee_adv_100tx));
